// ==== design/bufl_consts.svh ====
`ifndef BUFL_CONSTS_SVH
`define BUFL_CONSTS_SVH

// Channel count and fault word layout
`define BUFL_CH_NUM 6
`define BUFL_WORD_W 9
`define BUFL_LOAD_LSB 0
`define BUFL_UV_BIT 7
`define BUFL_OV_BIT 8

// Comparator thresholds in millivolts; the comparison itself is analog
`define BUFL_UV_THRESH_MV 4800
`define BUFL_INT_REF_MV 1250

// Reset values and synchroniser stage count
`define BUFL_WORD_RST 9'h000
`define BUFL_DRIVE_RST 6'h00
`define BUFL_FLAG_N_RST 1'b1
`define BUFL_FLAG_OE_RST 1'b0
`define BUFL_SYNC_STAGES 2
// Control chain order is uv, ov, chip select, strap; chip select rests high
// so that no false capture edge follows reset
`define BUFL_CTL_SYNC_RST 4'h2
`define BUFL_CS_IDLE 1'b1

`endif

// ==== design/bufl_pkg.sv ====
package bufl_pkg;

    // Fault flag line state
    typedef enum logic [0:0] {
        BUFL_FLAG_RELEASED,
        BUFL_FLAG_HELD
    } bufl_flag_state_t;

    // Meaning of the reference select level
    typedef enum logic [0:0] {
        BUFL_REF_INTERNAL,
        BUFL_REF_EXTERNAL
    } bufl_ref_sel_t;

endpackage : bufl_pkg

// ==== design/bufl_sync.sv ====
`timescale 1ns/100ps
`include "bufl_consts.svh"

// Two-stage synchroniser for a bundle of unrelated level signals
module bufl_sync
    import bufl_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r; // First stage, read only by the second
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r; // Second stage, safe to use
    logic [WIDTH-1:0] sync_nxt;

    if (WIDTH < 1)
    begin : g_chk
        $error("bufl_sync: WIDTH must be at least 1");
    end

    // Next values of the chain
    always_comb
    begin
        meta_nxt = async_i;
        sync_nxt = meta_r;
    end

    // Chain registers
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            // Idle level of each pin, so a reset does not fake an edge
            meta_r <= RST_VAL;
            sync_r <= RST_VAL;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_o = sync_r;

endmodule : bufl_sync

// ==== design/bufl_top.sv ====
// Overview of operation
// [RQ1] Undervoltage holds all six gate drives off
// [RQ2] Never switch FETs on at low battery
// [RQ3] Drives follow commands again after undervoltage clears
// [RQ4] Undervoltage pulls the open-drain fault flag low
// [RQ5] Fault word bit 7 marks undervoltage at capture
// [RQ6] Undervoltage hides open and shorted load faults
// [RQ7] Cleared undervoltage before capture is not recorded
// [RQ8] Chip select fall releases flag if fault-free
// [RQ9] Load faults compare drain against selected reference
// [RQ10] Reference select low internal, high external
// [RQ11] Fault word bits 0-5 flag channel load faults
// [RQ12] Fault word bit 8 marks battery overvoltage
// [RQ13] Controller clears false faults after power-up
// [RQ14] Load reporting returns once undervoltage clears
// [RQ15] Chip select fall snapshots live faults
`timescale 1ns/100ps
`include "bufl_consts.svh"

module bufl_top
    import bufl_pkg::*;
#(
    parameter int CH_NUM = `BUFL_CH_NUM
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic uv_cmp_i,
    input wire logic ov_cmp_i,
    input wire logic cs_n_i,
    input wire logic ext_ref_select_i,
    input wire logic [CH_NUM-1:0] par_on_i,
    input wire logic [CH_NUM-1:0] ser_on_i,
    input wire logic [CH_NUM-1:0] load_sense_in_int_i,
    input wire logic [CH_NUM-1:0] load_sense_in_ext_i,
    output logic [CH_NUM-1:0] fet_drive_out_o,
    output logic [`BUFL_WORD_W-1:0] fault_word_o,
    output logic fault_flag_n_o,
    output logic fault_flag_n_oe_o
);

    // The load bits must fit below the undervoltage bit of the word
    if (CH_NUM < 1 || CH_NUM > `BUFL_UV_BIT)
    begin : g_chk
        $error("bufl_top: CH_NUM must lie between 1 and 7");
    end

    // Synchronised copies of pin-level inputs
    logic uv_s; // Battery below threshold
    logic ov_s; // Battery above threshold
    logic cs_n_s; // Chip select, active low
    logic ref_sel_s; // Reference select level
    logic [CH_NUM-1:0] par_on_s; // Parallel on commands
    logic [CH_NUM-1:0] above_int_s; // Drain above internal reference
    logic [CH_NUM-1:0] above_ext_s; // Drain above external reference

    // Battery comparators, chip select and strap share one chain
    bufl_sync #(
        .WIDTH(4),
        .RST_VAL(`BUFL_CTL_SYNC_RST)
    ) u_sync_ctl (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i({uv_cmp_i, ov_cmp_i, cs_n_i, ext_ref_select_i}),
        .sync_o({uv_s, ov_s, cs_n_s, ref_sel_s})
    );

    // Parallel command pins act in real time, so they only pay the sync delay
    bufl_sync #(
        .WIDTH(CH_NUM)
    ) u_sync_par (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(par_on_i),
        .sync_o(par_on_s)
    );

    // Drain comparator against the internal reference
    bufl_sync #(
        .WIDTH(CH_NUM)
    ) u_sync_int (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(load_sense_in_int_i),
        .sync_o(above_int_s)
    );

    // Drain comparator against the external reference
    bufl_sync #(
        .WIDTH(CH_NUM)
    ) u_sync_ext (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(load_sense_in_ext_i),
        .sync_o(above_ext_s)
    );

    // Registered state
    logic [CH_NUM-1:0] drive_r; // Gate drive outputs
    logic [CH_NUM-1:0] drive_nxt;
    logic cs_prev_r; // Chip select one cycle back, for edge detect
    logic cs_prev_nxt;
    logic [`BUFL_WORD_W-1:0] word_r; // Serial fault status word
    logic [`BUFL_WORD_W-1:0] word_nxt;
    bufl_flag_state_t flag_r; // Fault flag state
    bufl_flag_state_t flag_nxt;
    logic flag_n_r; // Open-drain level, low while held
    logic flag_n_nxt;
    logic flag_oe_r; // Pin driven while held
    logic flag_oe_nxt;

    // Combinational helpers
    bufl_ref_sel_t ref_sel; // Decoded reference choice
    logic [CH_NUM-1:0] drain_above; // Drain above the selected reference
    logic [CH_NUM-1:0] load_flt; // Raw open or shorted load per channel
    logic [CH_NUM-1:0] load_rep; // Load faults that may be reported
    logic batt_flt; // Any battery fault present
    logic any_flt; // Any fault present right now
    logic cs_fall; // One-cycle pulse on chip select falling

    // Reference choice and per-channel load fault detection
    always_comb
    begin
        ref_sel = ref_sel_s ? BUFL_REF_EXTERNAL : BUFL_REF_INTERNAL; // RQ10
        // Pick one comparator bank per the strap
        if (ref_sel == BUFL_REF_EXTERNAL)
        begin
            drain_above = above_ext_s; // RQ9
        end
        else
        begin
            drain_above = above_int_s; // RQ9
        end
        // Off channel with low drain is open; on channel with high drain is shorted.
        // No deglitch window here: the analog front end filters before these pins.
        load_flt = (~drive_r & ~drain_above) | (drive_r & drain_above); // RQ9
        batt_flt = uv_s | ov_s;
        // Battery faults mask load reporting; it returns the cycle they clear
        load_rep = batt_flt ? '0 : load_flt; // RQ6 RQ14
        any_flt = batt_flt | (|load_rep);
        cs_fall = cs_prev_r & ~cs_n_s;
    end

    // Gate drives: either interface may turn a channel on, battery lockout wins
    always_comb
    begin
        drive_nxt = ser_on_i | par_on_s; // RQ3
        if (uv_s)
        begin
            // Low battery cannot fully enhance the FETs, keep them off
            drive_nxt = '0; // RQ1 RQ2
        end
        else if (ov_s)
        begin
            drive_nxt = '0;
        end
    end

    // Fault word: snapshot of live conditions on chip select falling
    always_comb
    begin
        word_nxt = word_r;
        cs_prev_nxt = cs_n_s;
        if (cs_fall)
        begin
            // A battery fault gone before the edge is simply absent here
            word_nxt = '0; // RQ15 RQ7
            word_nxt[`BUFL_LOAD_LSB +: CH_NUM] = load_rep; // RQ11
            word_nxt[`BUFL_UV_BIT] = uv_s; // RQ5
            word_nxt[`BUFL_OV_BIT] = ov_s; // RQ12
        end
    end

    // Fault flag: held by any fault, released only on a fault-free edge
    always_comb
    begin
        flag_nxt = flag_r;
        unique case (flag_r)
            BUFL_FLAG_RELEASED:
            begin
                // Take hold as soon as anything is wrong
                if (any_flt)
                begin
                    flag_nxt = BUFL_FLAG_HELD; // RQ4
                end
            end
            BUFL_FLAG_HELD:
            begin
                // A live fault outranks the release edge in the same cycle
                if (cs_fall && !any_flt)
                begin
                    flag_nxt = BUFL_FLAG_RELEASED; // RQ8
                end
            end
        endcase
        flag_n_nxt = (flag_nxt == BUFL_FLAG_RELEASED); // RQ4
        flag_oe_nxt = (flag_nxt == BUFL_FLAG_HELD);
    end

    // All registers of the block
    always_ff @(posedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            drive_r <= `BUFL_DRIVE_RST;
            cs_prev_r <= `BUFL_CS_IDLE;
            word_r <= `BUFL_WORD_RST;
            flag_r <= BUFL_FLAG_RELEASED;
            flag_n_r <= `BUFL_FLAG_N_RST;
            flag_oe_r <= `BUFL_FLAG_OE_RST;
        end
        else
        begin
            drive_r <= drive_nxt;
            cs_prev_r <= cs_prev_nxt;
            word_r <= word_nxt;
            flag_r <= flag_nxt;
            flag_n_r <= flag_n_nxt;
            flag_oe_r <= flag_oe_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign fet_drive_out_o = drive_r;
    assign fault_word_o = word_r;
    assign fault_flag_n_o = flag_n_r;
    assign fault_flag_n_oe_o = flag_oe_r;

endmodule : bufl_top

// ==== bench/bufl_top_properties.sv ====
`timescale 1ns/100ps
`include "bufl_consts.svh"
// Port-level checks of the battery fault logic
module bufl_top_properties
    import bufl_pkg::*;
#(
    parameter int CH_NUM = `BUFL_CH_NUM
)
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic uv_cmp_i,
    input wire logic ov_cmp_i,
    input wire logic cs_n_i,
    input wire logic ext_ref_select_i,
    input wire logic [CH_NUM-1:0] par_on_i,
    input wire logic [CH_NUM-1:0] ser_on_i,
    input wire logic [CH_NUM-1:0] load_sense_in_int_i,
    input wire logic [CH_NUM-1:0] load_sense_in_ext_i,
    input wire logic [CH_NUM-1:0] fet_drive_out_o,
    input wire logic [`BUFL_WORD_W-1:0] fault_word_o,
    input wire logic fault_flag_n_o,
    input wire logic fault_flag_n_oe_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // Level held around a chip select fall, long enough to cross the syncs
    sequence s_capt(c);
        (c)[*4] ##0 $fell(cs_n_i) ##1 ((c) && !cs_n_i)[*5];
    endsequence
    // No battery fault and steady commands
    sequence s_calm;
        (!uv_cmp_i && !ov_cmp_i && $stable(par_on_i) && $stable(ser_on_i))[*5];
    endsequence
    AST_UV_DRIVES_OFF: assert property (
        uv_cmp_i[*5] |-> fet_drive_out_o == '0) else $error("Drive on in undervoltage");
    AST_UV_FLAG_HELD: assert property (
        uv_cmp_i[*5] |-> !fault_flag_n_o && fault_flag_n_oe_o) else $error("Flag not held");
    AST_FLAG_OE_PAIR: assert property (
        fault_flag_n_oe_o == !fault_flag_n_o) else $error("Flag enable mismatch");
    AST_RECOVER: assert property (
        s_calm |-> fet_drive_out_o == (par_on_i | ser_on_i)) else $error("Drives not restored");
    AST_UV_CAPT: assert property (
        s_capt(uv_cmp_i) |-> fault_word_o[`BUFL_UV_BIT] &&
            fault_word_o[`BUFL_LOAD_LSB +: CH_NUM] == '0 && !fault_flag_n_o)
        else $error("Undervoltage capture wrong");
    AST_OV_CAPT: assert property (
        s_capt(ov_cmp_i) |-> fault_word_o[`BUFL_OV_BIT]) else $error("Overvoltage not captured");
    AST_UV_GONE: assert property (
        s_capt(!uv_cmp_i) |-> !fault_word_o[`BUFL_UV_BIT]) else $error("Stale undervoltage captured");
    AST_FLAG_REL: assert property (
        $rose(fault_flag_n_o) |-> !$past(cs_n_i, 3) || !$past(cs_n_i, 4))
        else $error("Flag released without chip select");
endmodule : bufl_top_properties

// ==== bench/bufl_ctrl_model.sv ====
`timescale 1ns/100ps
// Controller side: pulses chip select low for one status read
module bufl_ctrl_model
(
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic read_req_i,
    output logic cs_n_o,
    output logic busy_o
);
    logic [3:0] cnt_r; // Read phase countdown
    // Reset loads a read so false power-up faults get flushed
    always_ff @(negedge ref_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
            cnt_r <= 4'hC;
        else if (cnt_r != 4'h0)
            cnt_r <= cnt_r - 4'h1;
        else if (read_req_i)
            cnt_r <= 4'hC;
    end
    // Low six cycles, then a gap that outlasts the input syncs
    assign cs_n_o = !(cnt_r >= 4'h5 && cnt_r <= 4'hA);
    assign busy_o = cnt_r != 4'h0;
endmodule : bufl_ctrl_model

// ==== bench/tb_top.sv ====
`timescale 1ns/100ps
`include "bufl_consts.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top
    import bufl_pkg::*;
;
    localparam int CH_NUM = 6;
    logic ref_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic uv = 1'b0, ov = 1'b0, sel = 1'b0, rreq = 1'b0, cs_n, busy, flag_n, oe;
    logic [5:0] par = 6'h00, ser = 6'h00, s_int = 6'h00, s_ext = 6'h00, fet;
    logic [8:0] word;
    int error_cnt = 0;
    int tests_run = 0;
    int n;
    bufl_top #(.CH_NUM(CH_NUM)) bufl_top_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .uv_cmp_i(uv), .ov_cmp_i(ov), .cs_n_i(cs_n), .ext_ref_select_i(sel), .par_on_i(par),
        .ser_on_i(ser), .load_sense_in_int_i(s_int), .load_sense_in_ext_i(s_ext),
        .fet_drive_out_o(fet), .fault_word_o(word), .fault_flag_n_o(flag_n),
        .fault_flag_n_oe_o(oe));
    bufl_ctrl_model bufl_ctrl_model_inst (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .read_req_i(rreq), .cs_n_o(cs_n), .busy_o(busy));
    always #5 ref_clk_i = ~ref_clk_i;
    // Battery faults win over any on command
    function automatic logic [5:0] exp_drive();
        return (uv | ov) ? 6'h00 : (par | ser);
    endfunction : exp_drive
    // Word as captured from the present inputs
    function automatic logic [8:0] exp_word();
        logic [5:0] d, sn, ld;
        d = exp_drive();
        sn = sel ? s_ext : s_int;
        ld = (~d & ~sn) | (d & sn);
        return {ov, uv, 1'b0, (uv | ov) ? 6'h00 : ld};
    endfunction : exp_word
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report
    // Ask the controller model for a read and wait it out, bounded
    task do_read(input logic req);
        int k;
        rreq <= req;
        @(negedge ref_clk_i);
        rreq <= 1'b0;
        @(negedge ref_clk_i);
        for (k = 0; k < 40 && busy; k++)
            @(negedge ref_clk_i);
        if (busy)
        begin
            error_cnt++;
            final_report();
        end
    endtask : do_read
    task settle_chk;
        repeat (8) @(negedge ref_clk_i);
        `CHK(fet, exp_drive())
    endtask : settle_chk
    task read_chk;
        logic [8:0] w;
        w = exp_word();
        do_read(1'b1);
        `CHK(word, w)
        `CHK({flag_n, oe}, (|w) ? 2'b01 : 2'b10)
    endtask : read_chk
    initial
    begin
        repeat (3) @(negedge ref_clk_i);
        `CHK({fet, word, flag_n, oe}, 17'h00002)
        resetn_i <= 1'b1;
        void'($urandom(92));
        do_read(1'b0);
        for (n = 0; n < 40; n++)
        begin
            uv = ($urandom % 4) == 0;
            ov = ($urandom % 6) == 0;
            sel = 1'($urandom);
            par = 6'($urandom);
            ser = 6'($urandom);
            s_int = 6'($urandom);
            s_ext = 6'($urandom);
            if ($urandom % 2)
            begin
                s_int = ~exp_drive();
                s_ext = s_int;
            end
            settle_chk();
            read_chk();
        end
        $display("test random done");
        uv = 1'b0;
        ov = 1'b0;
        par = 6'h3F;
        ser = 6'h00;
        s_int = 6'h00;
        s_ext = 6'h00;
        settle_chk();
        read_chk();
        uv = 1'b1;
        settle_chk();
        `CHK({flag_n, oe}, 2'b01)
        uv = 1'b0;
        settle_chk();
        `CHK({flag_n, oe}, 2'b01)
        read_chk();
        $display("test uv_clear done");
        final_report();
    end
endmodule : tb_top
bind bufl_top bufl_top_properties #(.CH_NUM(CH_NUM)) bufl_top_properties_inst (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .uv_cmp_i(uv_cmp_i), .ov_cmp_i(ov_cmp_i),
    .cs_n_i(cs_n_i), .ext_ref_select_i(ext_ref_select_i), .par_on_i(par_on_i),
    .ser_on_i(ser_on_i), .load_sense_in_int_i(load_sense_in_int_i),
    .load_sense_in_ext_i(load_sense_in_ext_i), .fet_drive_out_o(fet_drive_out_o),
    .fault_word_o(fault_word_o), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_n_oe_o(fault_flag_n_oe_o));
